// ### hdl/spindle_pkg.sv
// Purpose: Shared constants and types for the spindle speed discriminator
// Assumes: 100 MHz system clock, nominal 1 MHz external reference
// Notes:   Times are kept in microseconds, cycle counts derive from them
`default_nettype none
package spindle_pkg;
    // System clock rate
    localparam int unsigned CLK_FREQ_MHZ = 100;

    // Discriminator counts in divided-reference ticks
    localparam int          CNT_W        = 12;
    localparam logic [11:0] CNT_HIGH     = 12'h56C;
    localparam logic [11:0] CNT_MED      = 12'h342;
    localparam logic [11:0] CNT_LOW      = 12'h682;

    // One-shot times, typical values
    localparam int unsigned T_DLY_LOW_US  = 2000;
    localparam int unsigned T_DLY_HIGH_US = 1670;
    localparam int unsigned T_DLY_MED_US  = 1000;
    localparam int unsigned T_WIDTH_US    = 2140;
    localparam int          TMR_W         = 18;

    // Three-level speed select after the level comparator
    typedef enum logic [1:0] {
        SPD_LOW  = 2'b00,
        SPD_MED  = 2'b01,
        SPD_HIGH = 2'b10
    } speed_sel_t;

    typedef enum logic [1:0] {
        ERR_NONE = 2'b00,
        ERR_SLOW = 2'b01,
        ERR_FAST = 2'b10
    } err_state_t;

    typedef enum logic [1:0] {
        IDX_IDLE  = 2'b00,
        IDX_DELAY = 2'b01,
        IDX_PULSE = 2'b10
    } idx_state_t;

    // Asynchronous pin inputs, synchronised together
    typedef struct packed {
        logic       osc;
        logic       tacho;
        logic       standby;
        logic       index;
        logic [1:0] speed;
    } pins_t;
endpackage
`default_nettype wire

// ### hdl/spindle_speed_discriminator.sv
// Purpose: Digital speed servo and index one-shots of a spindle driver
// Assumes: All pin inputs are asynchronous to i_clk
// Notes:   Speed error pin is out plus output enable, no high-Z inside
// How it works
// - Reference clock is oscillator divided by two
// - Count 1388 high, 834 medium, 1666 low
// - Error pulse length follows period difference
// - Lock when tacho period equals count ticks
// - Nominal lock 360, 600, 300 Hz tacho
// - Run when standby input low, idle when high
// - Hall bias off in standby, on running
// - Index delay 1.67, 1.00, 2.00 ms
// - Delay starts at index zero crossing
// - Then 2.14 ms timing output pulse
`default_nettype none
module spindle_speed_discriminator
    import spindle_pkg::*;
#(
    parameter int unsigned DLY_LOW_CYC  = T_DLY_LOW_US * CLK_FREQ_MHZ,
    parameter int unsigned DLY_HIGH_CYC = T_DLY_HIGH_US * CLK_FREQ_MHZ,
    parameter int unsigned DLY_MED_CYC  = T_DLY_MED_US * CLK_FREQ_MHZ,
    parameter int unsigned WIDTH_CYC    = T_WIDTH_US * CLK_FREQ_MHZ
) (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // Pins from the motor and controller
    input  wire logic       i_osc,
    input  wire logic       i_tacho_pulse,
    input  wire logic       i_run_standby_select,
    input  wire logic       i_index_sense_pos,
    input  wire logic [1:0] i_speed_select,
    // Pins to the integrator, sensors and controller
    output logic            o_speed_error_out,
    output logic            o_speed_error_oe,
    output logic            o_hall_bias_on,
    output logic            o_index_pulse_out
);
    import spindle_pkg::*;

    logic [1:0]       rst_sync_reg;
    logic             rst_n_s;
    pins_t            pins_raw;
    pins_t            meta_reg;
    pins_t            pins_reg;
    pins_t            prev_reg;
    logic             osc_rise;
    logic             tacho_rise;
    logic             index_rise;
    logic             standby;
    logic [CNT_W-1:0] target;
    logic [TMR_W-1:0] dly_load;

    logic             div_reg, div_next;
    logic             ref_tick_reg, ref_tick_next;
    err_state_t       err_reg, err_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [CNT_W-1:0] rem_reg, rem_next;
    logic             out_reg, out_next;
    logic             oe_reg, oe_next;
    logic             bias_reg, bias_next;
    idx_state_t       idx_reg, idx_next;
    logic [TMR_W-1:0] tmr_reg, tmr_next;
    logic             pulse_reg, pulse_next;

    // Reset release synchroniser
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n_s = rst_sync_reg[1];

    // Pin synchroniser and edge history
    assign pins_raw = '{osc: i_osc, tacho: i_tacho_pulse,
                        standby: i_run_standby_select,
                        index: i_index_sense_pos, speed: i_speed_select};

    always_ff @(posedge i_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            meta_reg <= '0;
            pins_reg <= '0;
            prev_reg <= '0;
        end else begin
            meta_reg <= pins_raw;
            pins_reg <= meta_reg;
            prev_reg <= pins_reg;
        end
    end

    assign osc_rise   = pins_reg.osc & ~prev_reg.osc;
    assign tacho_rise = pins_reg.tacho & ~prev_reg.tacho;
    assign index_rise = pins_reg.index & ~prev_reg.index;
    assign standby    = pins_reg.standby;

    // Count and delay chosen by the speed select level
    always_comb begin
        case (speed_sel_t'(pins_reg.speed))
            SPD_HIGH: begin
                target   = CNT_HIGH;
                dly_load = TMR_W'(DLY_HIGH_CYC - 1);
            end
            SPD_MED: begin
                target   = CNT_MED;
                dly_load = TMR_W'(DLY_MED_CYC - 1);
            end
            default: begin
                target   = CNT_LOW;
                dly_load = TMR_W'(DLY_LOW_CYC - 1);
            end
        endcase
    end

    // Speed discriminator next state
    always_comb begin
        div_next      = div_reg;
        ref_tick_next = 1'b0;
        err_next      = err_reg;
        cnt_next      = cnt_reg;
        rem_next      = rem_reg;
        if (standby) begin
            div_next = 1'b0;
            err_next = ERR_NONE;
            cnt_next = '0;
            rem_next = '0;
        end else begin
            if (osc_rise) begin
                div_next      = ~div_reg;
                ref_tick_next = div_reg;
            end
            if (tacho_rise) begin
                // Early edge means fast: low for the missing ticks
                cnt_next = '0;
                if (cnt_reg < target) begin
                    err_next = ERR_FAST;
                    rem_next = target - cnt_reg;
                end else begin
                    err_next = ERR_NONE;
                    rem_next = '0;
                end
            end else if (ref_tick_reg) begin
                if (cnt_reg < target) begin
                    cnt_next = cnt_reg + 1'b1;
                end
                if (cnt_reg + 1'b1 >= target) begin
                    // Period overran: slow until the next edge
                    err_next = ERR_SLOW;
                end else if (err_reg == ERR_FAST) begin
                    rem_next = rem_reg - 1'b1;
                    if (rem_reg == 12'h001) begin
                        err_next = ERR_NONE;
                    end
                end
            end
        end
        out_next  = (err_next == ERR_SLOW);
        oe_next   = (err_next != ERR_NONE);
        bias_next = ~standby;
    end

    always_ff @(posedge i_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            div_reg      <= 1'b0;
            ref_tick_reg <= 1'b0;
            err_reg      <= ERR_NONE;
            cnt_reg      <= '0;
            rem_reg      <= '0;
            out_reg      <= 1'b0;
            oe_reg       <= 1'b0;
            bias_reg     <= 1'b0;
        end else begin
            div_reg      <= div_next;
            ref_tick_reg <= ref_tick_next;
            err_reg      <= err_next;
            cnt_reg      <= cnt_next;
            rem_reg      <= rem_next;
            out_reg      <= out_next;
            oe_reg       <= oe_next;
            bias_reg     <= bias_next;
        end
    end

    // Index delay and width one-shots next state
    always_comb begin
        idx_next   = idx_reg;
        tmr_next   = tmr_reg;
        pulse_next = 1'b0;
        if (standby) begin
            idx_next = IDX_IDLE;
            tmr_next = '0;
        end else begin
            case (idx_reg)
                IDX_IDLE: begin
                    if (index_rise) begin
                        idx_next = IDX_DELAY;
                        tmr_next = dly_load;
                    end
                end
                IDX_DELAY: begin
                    if (tmr_reg == '0) begin
                        idx_next   = IDX_PULSE;
                        tmr_next   = TMR_W'(WIDTH_CYC - 1);
                        pulse_next = 1'b1;
                    end else begin
                        tmr_next = tmr_reg - 1'b1;
                    end
                end
                IDX_PULSE: begin
                    if (tmr_reg == '0) begin
                        idx_next = IDX_IDLE;
                    end else begin
                        tmr_next   = tmr_reg - 1'b1;
                        pulse_next = 1'b1;
                    end
                end
                default: begin
                    idx_next = IDX_IDLE;
                    tmr_next = '0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            idx_reg   <= IDX_IDLE;
            tmr_reg   <= '0;
            pulse_reg <= 1'b0;
        end else begin
            idx_reg   <= idx_next;
            tmr_reg   <= tmr_next;
            pulse_reg <= pulse_next;
        end
    end

    assign o_speed_error_out = out_reg;
    assign o_speed_error_oe  = oe_reg;
    assign o_hall_bias_on    = bias_reg;
    assign o_index_pulse_out = pulse_reg;

    a_ref_div_half: assert property (
        @(posedge i_clk) disable iff (!rst_n_s)
        ref_tick_reg |-> !div_reg && $past(osc_rise) && !ref_tick_next)
        else $error("reference tick not on every second osc edge");

    a_fast_length: assert property (
        @(posedge i_clk) disable iff (!rst_n_s)
        (tacho_rise && !standby && cnt_reg < target)
        |=> err_reg == ERR_FAST && rem_reg == $past(target - cnt_reg))
        else $error("fast error length not the tick shortfall");

    a_slow_count: assert property (
        @(posedge i_clk) disable iff (!rst_n_s)
        err_reg == ERR_SLOW |-> cnt_reg >= target)
        else $error("slow error before full count");

    a_standby_quiet: assert property (
        @(posedge i_clk) disable iff (!rst_n_s)
        standby |=> !o_speed_error_oe && !o_index_pulse_out && !o_hall_bias_on)
        else $error("activity while in standby");

    a_bias_resume: assert property (
        @(posedge i_clk) disable iff (!rst_n_s)
        $fell(standby) |=> o_hall_bias_on)
        else $error("hall bias not restored on run");

    a_delay_start: assert property (
        @(posedge i_clk) disable iff (!rst_n_s)
        (idx_reg == IDX_IDLE && index_rise && !standby)
        |=> idx_reg == IDX_DELAY && tmr_reg == $past(dly_load)
            && !o_index_pulse_out)
        else $error("index delay not loaded for speed");

    a_pulse_width: assert property (
        @(posedge i_clk) disable iff (!rst_n_s)
        (idx_reg == IDX_DELAY && tmr_reg == '0 && !standby)
        |=> o_index_pulse_out && tmr_reg == TMR_W'(WIDTH_CYC - 1))
        else $error("timing pulse not started after delay");

    a_err_drive: assert property (
        @(posedge i_clk) disable iff (!rst_n_s)
        o_speed_error_oe |-> o_speed_error_out == (err_reg == ERR_SLOW)
            && err_reg != ERR_NONE)
        else $error("speed error drive level wrong");

endmodule
`default_nettype wire

// ### tb/spindle_far_side.sv
// Purpose: Far side model: reference oscillator and tacho generator
// Assumes: Tacho period is given in clock cycles, changed off the wrap
// Notes:   Oscillator runs free at half the clock rate
`default_nettype none
module spindle_far_side (
    // Clock and requested tacho period
    input  wire logic        i_clk,
    input  wire logic [15:0] i_tacho_period,
    // Pins toward the discriminator
    output var logic         o_osc,
    output var logic         o_tacho_pulse
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] phase_reg  = 16'h0000;
    logic [15:0] period_reg = 16'h0C90;

    initial begin
        o_osc = 1'b0;
        o_tacho_pulse = 1'b0;
    end

    // New period taken only at the rising mark
    always @(negedge i_clk) begin
        o_osc <= !o_osc;
        if (phase_reg >= period_reg - 16'h0001) begin
            phase_reg     <= 16'h0000;
            period_reg    <= i_tacho_period;
            o_tacho_pulse <= 1'b1;
        end else begin
            phase_reg     <= phase_reg + 16'h0001;
            o_tacho_pulse <= (phase_reg + 16'h0001) < (period_reg >> 1);
        end
    end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Purpose: Self-checking bench of the spindle speed discriminator
// Assumes: One reference tick is four clock cycles in this bench
// Notes:   One-shot lengths shortened through parameters
`default_nettype none
module tb_top;
    import spindle_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int DLY_L = 40;
    localparam int DLY_H = 34;
    localparam int DLY_M = 20;
    localparam int WID   = 43;

    typedef struct packed {
        logic [1:0]  sel;
        logic [15:0] ticks;
        logic [15:0] fast;
        logic [15:0] slow;
    } row_t;

    // Count plus or minus 30 ticks gives 120 cycles of error
    localparam row_t ROWS [5] = '{
        '{2'b01, 16'h0324, 16'h0078, 16'h0000},
        '{2'b01, 16'h0360, 16'h0000, 16'h0078},
        '{2'b10, 16'h056C, 16'h0000, 16'h0000},
        '{2'b10, 16'h058A, 16'h0000, 16'h0078},
        '{2'b00, 16'h0664, 16'h0078, 16'h0000}
    };

    logic        clk     = 1'b0;
    logic        rst_n   = 1'b0;
    logic        standby = 1'b0;
    logic        index   = 1'b0;
    logic [1:0]  speed   = 2'b01;
    logic [15:0] period  = 16'h0C90;
    logic        osc;
    logic        tacho;
    logic        err_out;
    logic        err_oe;
    logic        bias;
    logic        idx_out;
    int          fails   = 0;
    int          n_tests = 0;

    spindle_speed_discriminator #(
        .DLY_LOW_CYC (DLY_L),
        .DLY_HIGH_CYC(DLY_H),
        .DLY_MED_CYC (DLY_M),
        .WIDTH_CYC   (WID)
    ) spindle_speed_discriminator_i (
        .i_clk               (clk),
        .i_rst_n             (rst_n),
        .i_osc               (osc),
        .i_tacho_pulse       (tacho),
        .i_run_standby_select(standby),
        .i_index_sense_pos   (index),
        .i_speed_select      (speed),
        .o_speed_error_out   (err_out),
        .o_speed_error_oe    (err_oe),
        .o_hall_bias_on      (bias),
        .o_index_pulse_out   (idx_out)
    );

    spindle_far_side spindle_far_side_i (
        .i_clk         (clk),
        .i_tacho_period(period),
        .o_osc         (osc),
        .o_tacho_pulse (tacho)
    );

    initial begin
        forever #5 clk = !clk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp, input int tol);
        logic ok;
        ok = (seen + tol >= exp) && (seen <= exp + tol);
        n_tests++;
        if (ok !== 1'b1) begin
            fails++;
            $display("wrong value %s expected %0d seen %0d", name, exp, seen);
        end
    endtask

    // Error cycles over one full tacho period, after one settle period
    task automatic run_row(input row_t r);
        logic [31:0] nf;
        logic [31:0] ns;
        nf = 0;
        ns = 0;
        @(negedge clk);
        speed = r.sel;
        period = {r.ticks[13:0], 2'b00};
        repeat (2) @(posedge tacho);
        @(posedge clk);
        while (tacho === 1'b1 || ns + nf == 0 && tacho === 1'b0) begin
            if (err_oe === 1'b1 && err_out === 1'b1) ns++;
            if (err_oe === 1'b1 && err_out !== 1'b1) nf++;
            @(posedge clk);
            if (tacho === 1'b0) break;
        end
        while (tacho === 1'b0) begin
            if (err_oe === 1'b1 && err_out === 1'b1) ns++;
            if (err_oe === 1'b1 && err_out !== 1'b1) nf++;
            @(posedge clk);
        end
        check("fast cycles", nf, r.fast, 8);
        check("slow cycles", ns, r.slow, 8);
    endtask

    // Index with a second crossing inside the delay
    task automatic index_run(input logic [1:0] sel, input int dly);
        int c;
        @(negedge clk);
        speed = sel;
        repeat (4) @(negedge clk);
        index = 1'b1;
        c = 0;
        while (idx_out !== 1'b1 && c < 300) begin
            @(negedge clk);
            c++;
            if (c == 5 || c == 15) index = 1'b0;
            if (c == 10) index = 1'b1;
        end
        check("index delay", c, dly + 3, 0);
        c = 0;
        while (idx_out === 1'b1 && c < 300) begin
            @(negedge clk);
            c++;
        end
        check("index width", c, WID, 0);
        c = 0;
        repeat (60) begin
            @(negedge clk);
            if (idx_out !== 1'b0) c++;
        end
        check("index repeat", c, 0, 0);
    endtask

    initial begin
        int hi;
        hi = 0;
        period = {ROWS[0].ticks[13:0], 2'b00};
        repeat (10) @(negedge clk);
        check("reset bias", bias, 0, 0);
        check("reset index", idx_out, 0, 0);
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (10) @(negedge clk);
        check("run bias", bias, 1, 0);
        foreach (ROWS[i]) begin
            run_row(ROWS[i]);
        end
        index_run(2'b11, DLY_L);
        index_run(2'b00, DLY_L);
        index_run(2'b10, DLY_H);
        index_run(2'b01, DLY_M);
        index = 1'b1;
        repeat (10) @(negedge clk);
        standby = 1'b1;
        index = 1'b0;
        repeat (10) @(negedge clk);
        check("standby bias", bias, 0, 0);
        check("standby error", err_oe, 0, 0);
        standby = 1'b0;
        repeat (100) begin
            @(negedge clk);
            if (idx_out !== 1'b0) hi++;
        end
        check("aborted index", hi, 0, 0);
        check("resumed bias", bias, 1, 0);
        complete_run();
    end

    initial begin
        repeat (90000) @(posedge clk);
        fails++;
        complete_run();
    end
endmodule
`default_nettype wire
